// file: rtl/rxm_defs.svh
// register offsets, field masks, reset values and timing counts of the receive mask block
`ifndef RXM_DEFS_SVH
`define RXM_DEFS_SVH

// register index offsets within one port bank (byte address is four times the index)
`define RXM_OFF_STAT3     9'h092
`define RXM_OFF_STAT4     9'h093
`define RXM_OFF_STAT5     9'h094
`define RXM_OFF_STAT7     9'h096
`define RXM_OFF_INFO      9'h09F
`define RXM_OFF_MASK3     9'h0A2
`define RXM_OFF_MASK4     9'h0A3
`define RXM_OFF_MASK5     9'h0A4
`define RXM_OFF_MASK7     9'h0A6
`define RXM_OFF_SCE1      9'h0A8
`define RXM_OFF_SCE2      9'h0A9
`define RXM_OFF_SCE3      9'h0AA
`define RXM_OFF_SCE4      9'h0AB
`define RXM_OFF_UP1       9'h0AC
`define RXM_OFF_UP2       9'h0AD
`define RXM_OFF_DN1       9'h0AE
`define RXM_OFF_DN2       9'h0AF
`define RXM_OFF_REALTIME  9'h0B2
`define RXM_OFF_CLR3      9'h0D2
`define RXM_OFF_CLR4      9'h0D3
`define RXM_OFF_CLR5      9'h0D4
`define RXM_OFF_CLR7      9'h0D6

// port bank stride in index units, and bit positions of the port field in the index
`define RXM_PORT_STRIDE   12'h200
`define RXM_PORT_LSB      9

// implemented bits of each mask register
`define RXM_M3_T1_BITS    8'hFF
`define RXM_M3_E1_BITS    8'hBB
`define RXM_M4_BITS       8'hEF
`define RXM_M5_BITS       8'h3F
`define RXM_M7_T1_BITS    8'h3F
`define RXM_M7_E1_BITS    8'h03

// signaling change flag position in the fourth status register
`define RXM_SIG_FLAG_BIT  3

// interrupt information bit positions
`define RXM_INFO_BIT3     2
`define RXM_INFO_BIT4     3
`define RXM_INFO_BIT5     4
`define RXM_INFO_BIT7     6

// reset values
`define RXM_RESET_BYTE    8'h00

// loop code integration length, in matching received bits
`define RXM_LOOP_INTEG    48

`endif

// file: rtl/rxm_pkg.sv
// shared types of the receive mask block
package rxm_pkg;

  // one 8-bit register value
  typedef logic [7:0] rxm_byte_t;

  // framing mode of a port
  typedef enum logic {RXM_MODE_T1, RXM_MODE_E1} rxm_mode_t;

endpackage : rxm_pkg

// file: rtl/rxm_loop_det.sv
// repeating loop code detector for one pattern of one port
`timescale 1ns/1ps
`include "rxm_defs.svh"

module rxm_loop_det #(
  parameter int INTEG = `RXM_LOOP_INTEG  // matching bits before the code counts as seen
) (
  input  wire logic        i_clock,      // system clock
  input  wire logic        i_rst,        // synchronous reset, active high
  input  wire logic        i_enable,     // detector active (t1 mode)
  input  wire logic        i_restart,    // one-cycle pulse, restart integration
  input  wire logic        i_bit_en,     // one-cycle pulse, a received bit is valid
  input  wire logic        i_bit,        // received bit
  input  wire logic [15:0] i_pattern,    // pattern, first bit at bit 15
  input  wire logic [3:0]  i_len_m1,     // pattern length minus one
  output logic             o_seen        // level, pattern being received
);

  localparam int CW = $clog2(INTEG + 1);
  localparam logic [CW-1:0] INTEG_C = CW'(INTEG);

  logic [3:0]    phase_r;                // position in the pattern
  logic [CW-1:0] count_r;                // consecutive matching bits, saturating
  logic          seen_r;                 // registered detect level

  // only the first L pattern bits are ever compared, so the rest are ignored
  wire           expected  = i_pattern[4'd15 - phase_r];
  wire           last      = (phase_r == i_len_m1);
  wire           hit       = (i_bit == expected);
  wire           restart_p = (i_bit == i_pattern[15]) && (i_len_m1 != 4'h0);
  wire [3:0]     phase_nxt = hit ? (last ? 4'h0 : phase_r + 4'h1) : (restart_p ? 4'h1 : 4'h0);
  wire [CW-1:0]  count_nxt = hit ? ((count_r == INTEG_C) ? count_r : count_r + CW'(1)) : CW'(0);

  // phase and integration count; a write of the first definition register restarts both
  always_ff @(posedge i_clock)
  begin
    if (i_rst || i_restart || !i_enable)
    begin
      phase_r <= 4'h0;
      count_r <= '0;
    end
    else if (i_bit_en)
    begin
      phase_r <= phase_nxt;
      count_r <= count_nxt;
    end
  end

  // detect level, held while the full integration run keeps matching
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      seen_r <= 1'b0;
    else
      seen_r <= i_enable && !i_restart && (count_r == INTEG_C);
  end

  assign o_seen = seen_r;

endmodule : rxm_loop_det

// file: rtl/rxm_top.sv
// eight-port receive interrupt mask, signaling enable and loop code definition registers over apb
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "rxm_defs.svh"

module rxm_top #(
  parameter int PORTS = 8,                     // number of port banks
  parameter int INTEG = `RXM_LOOP_INTEG        // loop code integration bits
) (
  input  wire logic              i_clock,      // 125 mhz system clock
  input  wire logic              i_rst,        // synchronous reset, active high
  input  wire logic              i_psel,       // apb select
  input  wire logic              i_penable,    // apb access phase
  input  wire logic              i_pwrite,     // apb direction, high for write
  input  wire logic [13:0]       i_paddr,      // apb byte address
  input  wire logic [31:0]       i_pwdata,     // apb write data
  output logic      [31:0]       o_prdata,     // apb read data
  output logic                   o_pready,     // apb ready
  output logic                   o_pslverr,    // apb error on unmapped access
  input  wire logic [PORTS-1:0]  i_e1_mode,    // per port, high for e1 framing
  input  wire logic [PORTS*8-1:0]  i_evt3,     // third status event pulses
  input  wire logic [PORTS*8-1:0]  i_evt4,     // fourth status event pulses
  input  wire logic [PORTS*8-1:0]  i_evt5,     // hdlc status event pulses
  input  wire logic [PORTS*8-1:0]  i_evt7,     // seventh status event pulses
  input  wire logic [PORTS*32-1:0] i_sig_change, // per channel signaling change pulses
  input  wire logic [PORTS-1:0]  i_rx_bit_en,  // received bit valid pulse
  input  wire logic [PORTS-1:0]  i_rx_bit,     // received bit
  input  wire logic [PORTS*4-1:0]  i_code_len, // loop code length minus one
  output logic      [PORTS-1:0]  o_loop_up_seen,   // loop-up code being received
  output logic      [PORTS-1:0]  o_loop_down_seen, // loop-down code being received
  output logic      [PORTS-1:0]  o_port_irq,   // per port interrupt request
  output logic                   o_irq         // combined interrupt, level
);

  // apb index decode
  // the port field sits above the nine offset bits of the word index
  wire [11:0] acc_idx     = i_paddr[13:2];
  wire [2:0]  acc_port    = acc_idx[11:`RXM_PORT_LSB];
  wire [8:0]  acc_off     = acc_idx[`RXM_PORT_LSB-1:0];
  wire        acc_aligned = (i_paddr[1:0] == 2'h0);
  wire        acc_port_ok = (32'(acc_port) < PORTS);
  wire        acc_access  = i_psel & i_penable;
  // a transfer is taken only at the edge where ready is seen high
  wire        acc_fire    = acc_access & o_pready;
  wire        wr_fire     = acc_fire & i_pwrite & acc_aligned & acc_port_ok;

  // per port register storage
  // each port keeps its own copy of every register, so banks never share state
  rxm_pkg::rxm_byte_t m3_r  [0:PORTS-1];       // third mask
  rxm_pkg::rxm_byte_t m4_r  [0:PORTS-1];       // fourth mask
  rxm_pkg::rxm_byte_t m5_r  [0:PORTS-1];       // hdlc mask
  rxm_pkg::rxm_byte_t m7_r  [0:PORTS-1];       // seventh mask
  rxm_pkg::rxm_byte_t sce_r [0:PORTS-1][0:3];  // signaling change enables
  rxm_pkg::rxm_byte_t up_r  [0:PORTS-1][0:1];  // loop-up definition pair
  rxm_pkg::rxm_byte_t dn_r  [0:PORTS-1][0:1];  // loop-down definition pair
  rxm_pkg::rxm_byte_t st3_r [0:PORTS-1];       // third latched status
  rxm_pkg::rxm_byte_t st4_r [0:PORTS-1];       // fourth latched status
  rxm_pkg::rxm_byte_t st5_r [0:PORTS-1];       // hdlc latched status
  rxm_pkg::rxm_byte_t st7_r [0:PORTS-1];       // seventh latched status
  rxm_pkg::rxm_byte_t info_w [0:PORTS-1];      // interrupt information
  logic [PORTS-1:0]   up_seen_w;               // loop-up detect levels
  logic [PORTS-1:0]   dn_seen_w;               // loop-down detect levels
  logic [PORTS-1:0]   port_irq_w;              // per port request, before register

  logic [31:0] prdata_r;                       // registered read data
  logic        pready_r;                       // registered ready
  logic        pslverr_r;                      // registered error
  logic [PORTS-1:0] port_irq_r;                // registered per port request
  logic        irq_r;                          // registered combined request
  logic [PORTS-1:0] up_seen_r;                 // registered loop-up level
  logic [PORTS-1:0] dn_seen_r;                 // registered loop-down level

  // one bank of registers, status and detectors per port
  genvar p;
  generate
    for (p = 0; p < PORTS; p++)
    begin : g_port
      // write strobes of this bank
      // refused accesses (unmapped, misaligned, missing port) never raise a strobe
      wire wr_p    = wr_fire & (32'(acc_port) == p);
      wire wr_m3   = wr_p & (acc_off == `RXM_OFF_MASK3);
      wire wr_m4   = wr_p & (acc_off == `RXM_OFF_MASK4);
      wire wr_m5   = wr_p & (acc_off == `RXM_OFF_MASK5);
      wire wr_m7   = wr_p & (acc_off == `RXM_OFF_MASK7);
      wire wr_sce1 = wr_p & (acc_off == `RXM_OFF_SCE1);
      wire wr_sce2 = wr_p & (acc_off == `RXM_OFF_SCE2);
      wire wr_sce3 = wr_p & (acc_off == `RXM_OFF_SCE3);
      wire wr_sce4 = wr_p & (acc_off == `RXM_OFF_SCE4);
      wire wr_up1  = wr_p & (acc_off == `RXM_OFF_UP1);
      wire wr_up2  = wr_p & (acc_off == `RXM_OFF_UP2);
      wire wr_dn1  = wr_p & (acc_off == `RXM_OFF_DN1);
      wire wr_dn2  = wr_p & (acc_off == `RXM_OFF_DN2);
      wire wr_c3   = wr_p & (acc_off == `RXM_OFF_CLR3);
      wire wr_c4   = wr_p & (acc_off == `RXM_OFF_CLR4);
      wire wr_c5   = wr_p & (acc_off == `RXM_OFF_CLR5);
      wire wr_c7   = wr_p & (acc_off == `RXM_OFF_CLR7);
      wire [7:0] wbyte = i_pwdata[7:0];
      wire e1 = i_e1_mode[p];

      // mask registers; masks reset to zero so nothing interrupts
      // reserved mask bits are dropped on write, so they read back as zero
      always_ff @(posedge i_clock)
      begin
        if (i_rst)
        begin
          m3_r[p] <= `RXM_RESET_BYTE;
          m4_r[p] <= `RXM_RESET_BYTE;
          m5_r[p] <= `RXM_RESET_BYTE;
          m7_r[p] <= `RXM_RESET_BYTE;
        end
        else
        begin
          if (wr_m3) m3_r[p] <= wbyte;
          if (wr_m4) m4_r[p] <= wbyte & `RXM_M4_BITS;
          if (wr_m5) m5_r[p] <= wbyte & `RXM_M5_BITS;
          if (wr_m7) m7_r[p] <= wbyte & `RXM_M7_T1_BITS;
        end
      end

      // channel enables and loop code definitions
      // a write of a first definition register also restarts its detector
      always_ff @(posedge i_clock)
      begin
        if (i_rst)
        begin
          sce_r[p] <= '{default: `RXM_RESET_BYTE};
          up_r[p]  <= '{default: `RXM_RESET_BYTE};
          dn_r[p]  <= '{default: `RXM_RESET_BYTE};
        end
        else
        begin
          if (wr_sce1) sce_r[p][0] <= wbyte;
          if (wr_sce2) sce_r[p][1] <= wbyte;
          if (wr_sce3) sce_r[p][2] <= wbyte;
          if (wr_sce4) sce_r[p][3] <= wbyte;
          if (wr_up1)  up_r[p][0]  <= wbyte;
          if (wr_up2)  up_r[p][1]  <= wbyte;
          if (wr_dn1)  dn_r[p][0]  <= wbyte;
          if (wr_dn2)  dn_r[p][1]  <= wbyte;
        end
      end

      // mask bits that apply in the current framing mode
      // stored bits stay as written; the framing mode only decides which of them act
      wire [7:0] m3_eff = m3_r[p] & (e1 ? `RXM_M3_E1_BITS : `RXM_M3_T1_BITS);
      wire [7:0] m4_eff = m4_r[p];
      wire [7:0] m5_eff = m5_r[p];
      wire [7:0] m7_eff = m7_r[p] & (e1 ? `RXM_M7_E1_BITS : `RXM_M7_T1_BITS);

      // signaling change: channels 25 to 32 take part only in e1
      // the fourth enable register is still stored and read back in t1
      wire [7:0]  sce4_eff = e1 ? sce_r[p][3] : 8'h00;
      wire [31:0] sce_all  = {sce4_eff, sce_r[p][2], sce_r[p][1], sce_r[p][0]};
      wire        sig_hit  = |(i_sig_change[p*32 +: 32] & sce_all);

      // event vectors entering the sticky status registers
      // bit 3 of the fourth status comes from the signaling change, not from an event pin
      // a clear write acts only on the bits written as one
      wire [7:0] ev3 = i_evt3[p*8 +: 8];
      wire [7:0] ev4 = {i_evt4[p*8+7 -: 3], 1'b0, sig_hit, i_evt4[p*8 +: 3]};
      wire [7:0] ev5 = i_evt5[p*8 +: 8] & `RXM_M5_BITS;
      wire [7:0] ev7 = i_evt7[p*8 +: 8] & `RXM_M7_T1_BITS;
      wire [7:0] c3  = wr_c3 ? wbyte : 8'h00;
      wire [7:0] c4  = wr_c4 ? wbyte : 8'h00;
      wire [7:0] c5  = wr_c5 ? wbyte : 8'h00;
      wire [7:0] c7  = wr_c7 ? wbyte : 8'h00;

      // sticky status; a new event in the clearing cycle keeps its bit set
      // status latches even while masked; the mask gates only the request and the info byte
      always_ff @(posedge i_clock)
      begin
        if (i_rst)
        begin
          st3_r[p] <= `RXM_RESET_BYTE;
          st4_r[p] <= `RXM_RESET_BYTE;
          st5_r[p] <= `RXM_RESET_BYTE;
          st7_r[p] <= `RXM_RESET_BYTE;
        end
        else
        begin
          st3_r[p] <= (st3_r[p] & ~c3) | ev3;
          st4_r[p] <= (st4_r[p] & ~c4) | ev4;
          st5_r[p] <= (st5_r[p] & ~c5) | ev5;
          st7_r[p] <= (st7_r[p] & ~c7) | ev7;
        end
      end

      // a status register is pending only through its enabled bits
      // the request follows the status one edge later, so a clear drops it one edge after the write
      wire pend3 = |(st3_r[p] & m3_eff);
      wire pend4 = |(st4_r[p] & m4_eff);
      wire pend5 = |(st5_r[p] & m5_eff);
      wire pend7 = |(st7_r[p] & m7_eff);

      // information byte and port request from the masked status only
      // unused info positions stay zero
      assign info_w[p] = {1'b0, pend7, 1'b0, pend5, pend4, pend3, 2'b00};
      assign port_irq_w[p] = pend3 | pend4 | pend5 | pend7;

      // loop-up detector; only a write of the first register restarts it
      // both detectors share the received bit and the length; the second registers act only past eight bits
      rxm_loop_det #(
        .INTEG     (INTEG)
      ) u_up (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_enable  (!e1),
        .i_restart (wr_up1),
        .i_bit_en  (i_rx_bit_en[p]),
        .i_bit     (i_rx_bit[p]),
        .i_pattern ({up_r[p][0], up_r[p][1]}),
        .i_len_m1  (i_code_len[p*4 +: 4]),
        .o_seen    (up_seen_w[p])
      );

      // loop-down detector
      rxm_loop_det #(
        .INTEG     (INTEG)
      ) u_dn (
        .i_clock   (i_clock),
        .i_rst     (i_rst),
        .i_enable  (!e1),
        .i_restart (wr_dn1),
        .i_bit_en  (i_rx_bit_en[p]),
        .i_bit     (i_rx_bit[p]),
        .i_pattern ({dn_r[p][0], dn_r[p][1]}),
        .i_len_m1  (i_code_len[p*4 +: 4]),
        .o_seen    (dn_seen_w[p])
      );
    end
  endgenerate

  // read selection within the addressed bank
  // write-only offsets read as zero without an error; reserved offsets are not mapped and answer with an error
  // a missing port reads bank 0 only to keep the index legal; the answer is refused anyway
  logic [7:0] rd_val;   // selected byte
  logic       rd_map;   // offset is mapped
  wire  [2:0] rp = acc_port_ok ? acc_port : 3'h0;
  always_comb
  begin
    rd_val = 8'h00;
    rd_map = 1'b1;
    case (acc_off)
      `RXM_OFF_STAT3:    rd_val = st3_r[rp];
      `RXM_OFF_STAT4:    rd_val = st4_r[rp];
      `RXM_OFF_STAT5:    rd_val = st5_r[rp];
      `RXM_OFF_STAT7:    rd_val = st7_r[rp];
      `RXM_OFF_INFO:     rd_val = info_w[rp];
      `RXM_OFF_MASK3:    rd_val = m3_r[rp];
      `RXM_OFF_MASK4:    rd_val = m4_r[rp];
      `RXM_OFF_MASK5:    rd_val = m5_r[rp];
      `RXM_OFF_MASK7:    rd_val = m7_r[rp];
      `RXM_OFF_SCE1:     rd_val = sce_r[rp][0];
      `RXM_OFF_SCE2:     rd_val = sce_r[rp][1];
      `RXM_OFF_SCE3:     rd_val = sce_r[rp][2];
      `RXM_OFF_SCE4:     rd_val = sce_r[rp][3];
      `RXM_OFF_UP1:      rd_val = up_r[rp][0];
      `RXM_OFF_UP2:      rd_val = up_r[rp][1];
      `RXM_OFF_DN1:      rd_val = dn_r[rp][0];
      `RXM_OFF_DN2:      rd_val = dn_r[rp][1];
      `RXM_OFF_REALTIME: rd_val = {6'h00, dn_seen_r[rp], up_seen_r[rp]};
      `RXM_OFF_CLR3,
      `RXM_OFF_CLR4,
      `RXM_OFF_CLR5,
      `RXM_OFF_CLR7:     rd_val = 8'h00;
      default:           rd_map = 1'b0;
    endcase
  end

  // an access is good only when mapped, aligned and inside an existing bank
  wire acc_ok = rd_map & acc_aligned & acc_port_ok;

  // apb answer: ready one cycle into the access phase, then released
  // exactly one wait state; data and error are taken in the same cycle as ready
  // ready is a one-cycle pulse; a request still held after it is answered again one cycle after ready drops
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (acc_access && !pready_r)
    begin
      pready_r  <= 1'b1;
      prdata_r  <= (acc_ok && !i_pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      pslverr_r <= !acc_ok;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // registered interrupt and detect outputs
  // every output leaves from a flip-flop, one edge behind its source
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      port_irq_r <= '0;
      irq_r      <= 1'b0;
      up_seen_r  <= '0;
      dn_seen_r  <= '0;
    end
    else
    begin
      port_irq_r <= port_irq_w;
      irq_r      <= |port_irq_w;
      up_seen_r  <= up_seen_w;
      dn_seen_r  <= dn_seen_w;
    end
  end

  assign o_prdata         = prdata_r;
  assign o_pready         = pready_r;
  assign o_pslverr        = pslverr_r;
  assign o_port_irq       = port_irq_r;
  assign o_irq            = irq_r;
  assign o_loop_up_seen   = up_seen_r;
  assign o_loop_down_seen = dn_seen_r;

endmodule : rxm_top

// file: verification/rxm_top_asserts.sv
// port level checks of the receive mask block
`timescale 1ns/1ps
module rxm_top_asserts #(
  parameter int PORTS = 8              // number of port banks
) (
  input wire logic             i_clock,
  input wire logic             i_rst,
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic [13:0]      i_paddr,
  input wire logic [31:0]      o_prdata,
  input wire logic             o_pready,
  input wire logic             o_pslverr,
  input wire logic [PORTS-1:0] o_port_irq,
  input wire logic             o_irq
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // apb setup then access
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable;
  endsequence
  wait_state_a: assert property (s_setup ##1 s_access |-> !o_pready ##1 o_pready)
    else $error("ready not after one wait state");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  idle_quiet_a: assert property (!i_psel |=> !o_pready)
    else $error("ready without select");
  err_ready_a: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0)
    else $error("error without ready or with data");
  align_err_a: assert property ((i_psel && !i_penable && i_paddr[1:0] != 2'h0) ##1 s_access |=> o_pslverr)
    else $error("misaligned access not refused");
  upper_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  irq_or_a: assert property (o_irq == (|o_port_irq))
    else $error("combined request not or of ports");
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> o_port_irq == '0 && !o_irq && !o_pready)
    else $error("outputs active after reset");
endmodule : rxm_top_asserts

// file: verification/tb_top.sv
// self-checking bench of the receive mask block
`timescale 1ns/1ps
`include "rxm_defs.svh"
module tb_top;
  localparam int PORTS = 8;
  logic         i_clock, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, er;
  logic [13:0]  i_paddr;
  logic [31:0]  i_pwdata, o_prdata, rd, i_code_len;
  logic [63:0]  ev [4];                  // event pulses of the four status registers
  logic [255:0] i_sig_change;
  logic [7:0]   i_e1_mode, i_rx_bit_en, i_rx_bit, o_loop_up_seen, o_loop_down_seen, o_port_irq;
  int           num_errors, checks;
  // register tables
  logic [8:0] regs [12] = '{9'h0A2, 9'h0A3, 9'h0A4, 9'h0A6, 9'h0A8, 9'h0A9, 9'h0AA, 9'h0AB,
                            9'h0AC, 9'h0AD, 9'h0AE, 9'h0AF};
  logic [7:0] wexp [12] = '{8'hFF, 8'hEF, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
                            8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [8:0] stat [4] = '{`RXM_OFF_STAT3, `RXM_OFF_STAT4, `RXM_OFF_STAT5, `RXM_OFF_STAT7};
  logic [8:0] clr [4] = '{`RXM_OFF_CLR3, `RXM_OFF_CLR4, `RXM_OFF_CLR5, `RXM_OFF_CLR7};
  logic [7:0] info [4] = '{8'h04, 8'h08, 8'h10, 8'h40};

  rxm_top #(.PORTS(PORTS), .INTEG(4)) u_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_e1_mode(i_e1_mode), .i_evt3(ev[0]), .i_evt4(ev[1]), .i_evt5(ev[2]),
    .i_evt7(ev[3]), .i_sig_change(i_sig_change), .i_rx_bit_en(i_rx_bit_en), .i_rx_bit(i_rx_bit),
    .i_code_len(i_code_len), .o_loop_up_seen(o_loop_up_seen), .o_loop_down_seen(o_loop_down_seen),
    .o_port_irq(o_port_irq), .o_irq(o_irq)
  );

  // free running clock
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // byte address of a register in a port bank
  function automatic logic [13:0] ad(input int p, input logic [8:0] off);
    return {p[2:0], off, 2'b00};
  endfunction : ad

  // one apb transfer, request held until ready seen high
  task automatic apb(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clock);
    i_penable <= 1'b1;
    do
      @(posedge i_clock);
    while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input int p, input logic [8:0] off, input logic [7:0] d);
    apb(1'b1, ad(p, off), d);
  endtask : wr

  task automatic rdc(input int p, input logic [8:0] off, input logic [7:0] e);
    apb(1'b0, ad(p, off), 8'h00);
    check(rd, {24'h0, e});
  endtask : rdc

  // let registered outputs settle, sample mid cycle
  task automatic settle;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
  endtask : settle

  // one event pulse on status register k
  task automatic pulse(input int k, input int p, input int b);
    @(posedge i_clock);
    ev[k][8*p+b] <= 1'b1;
    @(posedge i_clock);
    ev[k] <= '0;
    settle();
  endtask : pulse

  // one signaling change pulse
  task automatic sig(input int n);
    @(posedge i_clock);
    i_sig_change[n] <= 1'b1;
    @(posedge i_clock);
    i_sig_change <= '0;
    settle();
  endtask : sig

  // received bits on port 0
  task automatic bits(input logic b);
    repeat (8)
    begin
      @(posedge i_clock);
      i_rx_bit_en[0] <= 1'b1;
      i_rx_bit[0] <= b;
      @(posedge i_clock);
      i_rx_bit_en[0] <= 1'b0;
    end
    settle();
  endtask : bits

  task automatic final_report;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // hang guard
  initial
  begin
    repeat (20000) @(posedge i_clock);
    num_errors++;
    final_report();
  end

  // main sequence
  initial
  begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    ev = '{default: '0};
    {i_sig_change, i_e1_mode, i_rx_bit_en, i_rx_bit, i_code_len} = '0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    // reset values, reserved bits, port stride
    foreach (regs[i]) rdc(0, regs[i], 8'h00);
    foreach (regs[i])
    begin
      wr(5, regs[i], 8'hFF);
      rdc(5, regs[i], wexp[i]);
    end
    rdc(4, `RXM_OFF_MASK4, 8'h00);
    // unmapped and misaligned accesses refused
    apb(1'b0, ad(0, 9'h0FF), 8'h00);
    check({31'h0, er}, 32'h1);
    apb(1'b1, ad(0, `RXM_OFF_MASK4) | 14'h1, 8'hFF);
    check({31'h0, er}, 32'h1);
    rdc(0, `RXM_OFF_MASK4, 8'h00);
    // each status register: blocked, passed, shown, cleared
    for (int k = 0; k < 4; k++)
    begin
      pulse(k, 2, 1);
      check(32'(o_port_irq), 32'h0);
      rdc(2, stat[k], 8'h02);
      rdc(2, `RXM_OFF_INFO, 8'h00);
      wr(2, regs[k], 8'h02);
      settle();
      check(32'(o_port_irq), 32'h4);
      check(32'(o_irq), 32'h1);
      rdc(2, `RXM_OFF_INFO, info[k]);
      wr(2, clr[k], 8'h02);
      settle();
      check(32'(o_port_irq), 32'h0);
      check(32'(o_irq), 32'h0);
      wr(2, regs[k], 8'h00);
    end
    // e1 seventh mask: codeword and sa change bits, others ineffective
    i_e1_mode[3] <= 1'b1;
    wr(3, `RXM_OFF_MASK7, 8'h3F);
    for (int b = 0; b < 2; b++)
    begin
      pulse(3, 3, b);
      check(32'(o_port_irq), 32'h8);
      wr(3, `RXM_OFF_CLR7, 8'h01 << b);
    end
    pulse(3, 3, 5);
    check(32'(o_port_irq), 32'h0);
    // signaling change enables, channel 32 only in e1
    wr(2, `RXM_OFF_SCE1, 8'h01);
    wr(2, `RXM_OFF_SCE4, 8'h80);
    sig(64);
    rdc(2, `RXM_OFF_STAT4, 8'h08);
    wr(2, `RXM_OFF_CLR4, 8'h08);
    sig(65);
    sig(95);
    rdc(2, `RXM_OFF_STAT4, 8'h00);
    i_e1_mode[2] <= 1'b1;
    sig(95);
    rdc(2, `RXM_OFF_STAT4, 8'h08);
    // loop codes, one bit length, low bits ignored
    wr(0, `RXM_OFF_UP1, 8'h80);
    wr(0, `RXM_OFF_DN1, 8'h7F);
    wr(0, `RXM_OFF_DN2, 8'hFF);
    bits(1'b1);
    check({o_loop_down_seen[0], o_loop_up_seen[0]}, 32'h1);
    rdc(0, `RXM_OFF_REALTIME, 8'h01);
    bits(1'b0);
    check({o_loop_down_seen[0], o_loop_up_seen[0]}, 32'h2);
    wr(0, `RXM_OFF_DN1, 8'h7F);
    settle();
    check({o_loop_down_seen[0], o_loop_up_seen[0]}, 32'h0);
    i_e1_mode[0] <= 1'b1;
    bits(1'b0);
    check({o_loop_down_seen[0], o_loop_up_seen[0]}, 32'h0);
    final_report();
  end
endmodule : tb_top

bind rxm_top rxm_top_asserts #(.PORTS(PORTS)) u_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_port_irq(o_port_irq), .o_irq(o_irq)
);
